// ==== shared/sbtrtc_defs.svh ====
/*
 Register indices, field positions, reset values and prescale
 counts of the 16-bit timer with real-time clock mode.
 Assumes a 32-bit APB with byte address = 4 x register index.
*/
`ifndef SBTRTC_DEFS_SVH
`define SBTRTC_DEFS_SVH

`define SBT_AW          12
`define SBT_IDX_COUNT   10'h100
`define SBT_IDX_PERIOD  10'h102
`define SBT_IDX_CTRL    10'h104
`define SBT_IDX_FLAG    10'h110
`define SBT_IDX_ENABLE  10'h111
`define SBT_IDX_OSC     10'h112

`define SBT_B_TON       15
`define SBT_B_SIDL      13
`define SBT_B_GATED_ACCUMULATE_ENABLE     6
`define SBT_B_CKPS_HI   5
`define SBT_B_CKPS_LO   4
`define SBT_B_EXT_CLOCK_SYNC     2
`define SBT_B_TCS       1
`define SBT_B_LPOSC     1
`define SBT_B_PERIOD    0
`define SBT_B_WAKE      1

`define SBT_PERIOD_RST  16'hFFFF
`define SBT_COUNT_RST   16'h0000
`define SBT_PS_1        8'h00
`define SBT_PS_8        8'h07
`define SBT_PS_64       8'h3F
`define SBT_PS_256      8'hFF

`endif

// ==== shared/sbtrtc_pkg.sv ====
/*
 Types of the 16-bit timer with real-time clock mode.
 Assumes nothing of its surroundings.
*/
package sbtrtc_pkg;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
        logic        timer_on;
        logic        sidl;
        logic        gated_accumulate_enable;
        logic [1:0]  ckps;
        logic        ext_clock_sync;
        logic        clock_source_select;
        logic        lposc;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [7:0]  pre;
        logic        ext_q;
        logic        sy1;
        logic        sy2;
        logic        sy3;
        logic        lp_q;
        logic        gate_q;
        logic        irq;
        logic        wake;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sbtrtc_state_s;

endpackage : sbtrtc_pkg

// ==== rtl/sbtrtc.sv ====
/*
 16-bit period timer with gated accumulation, prescaler, sleep/idle
 handling and low-power oscillator RTC mode, behind an APB slave.
 Assumes pins are synchronous to pclk and pclk runs through sleep.
*/
// Added by the designer: the APB register port.
// Notes on behaviour
// - in sleep count only when on, external source, asynchronous setting
// - count up to period value, then return to zero
// - period match in sleep raises a request only when enabled
// - count equal to period sets the flag and requests if enabled
// - gated mode also sets the flag on gate falling edge
// - request needs the enable bit; flag sets regardless
// - rtc mode counts rising edges of low-power oscillator to period
// - low-power oscillator enable stops timer modes, enables carry-out wake
// - rtc keeps running through sleep while the external sync bit is clear
// - stop-in-idle halts counting during idle; cleared keeps counting
// - prescale input by 1, 8, 64 or 256 per two-bit field
// - count or control write clears prescaler; control write keeps count
// - gated mode with internal clock counts only while gate high
`timescale 1ns/1ps
`include "sbtrtc_defs.svh"

module sbtrtc (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic [`SBT_AW-1:0] paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // pins
    input  wire logic               external_clock_gate_pin,
    input  wire logic               lowpower_osc_in,
    // cpu power state
    input  wire logic               cpu_sleep,
    input  wire logic               cpu_idle,
    // events
    output logic                    irq,
    output logic                    wake
);

    sbtrtc_pkg::sbtrtc_state_s st;
    sbtrtc_pkg::sbtrtc_state_s next_st;

    logic       acc;
    logic       wr;
    logic       wr_cnt;
    logic       wr_ctl;
    logic       tick;
    logic       match;
    logic       raw;
    logic       run;
    logic       gate_fall;
    logic [7:0] ratio;
    logic [9:0] idx;

    assign idx    = paddr[`SBT_AW-1:2];
    assign acc    = psel & penable & st.pready;
    assign wr     = acc & pwrite;
    assign wr_cnt = wr & (idx == `SBT_IDX_COUNT);
    assign wr_ctl = wr & (idx == `SBT_IDX_CTRL);
    assign match  = st.count == st.period;

    always_comb begin
        unique case (st.ckps)
            2'b00:   ratio = `SBT_PS_1;
            2'b01:   ratio = `SBT_PS_8;
            2'b10:   ratio = `SBT_PS_64;
            2'b11:   ratio = `SBT_PS_256;
        endcase
    end

    // sleep and idle gating of the whole count path
    assign run = st.timer_on
        & ~(cpu_sleep & ~(st.clock_source_select & ~st.ext_clock_sync))
        & ~(cpu_idle & st.sidl);

    always_comb begin
        if (st.clock_source_select) begin
            if (st.lposc) begin
                raw = lowpower_osc_in & ~st.lp_q;
            end else if (st.ext_clock_sync) begin
                raw = st.sy2 & ~st.sy3;
            end else begin
                raw = external_clock_gate_pin & ~st.ext_q;
            end
        end else if (st.lposc) begin
            raw = 1'b0;
        end else if (st.gated_accumulate_enable) begin
            raw = external_clock_gate_pin;
        end else begin
            raw = 1'b1;
        end
    end

    assign tick = run & raw & (st.pre == ratio) & ~wr_cnt & ~wr_ctl;
    assign gate_fall = st.timer_on & st.gated_accumulate_enable & ~st.clock_source_select & ~st.lposc
        & st.gate_q & ~external_clock_gate_pin;

    always_comb begin
        next_st = st;
        // input sampling; sy1 feeds only sy2
        next_st.sy1    = external_clock_gate_pin;
        next_st.sy2    = st.sy1;
        next_st.sy3    = st.sy2;
        next_st.ext_q  = external_clock_gate_pin;
        next_st.gate_q = external_clock_gate_pin;
        next_st.lp_q   = lowpower_osc_in;
        next_st.wake   = 1'b0;

        // prescaler
        if (wr_cnt | wr_ctl) begin
            next_st.pre = 8'h00;
        end else if (run & raw) begin
            next_st.pre = (st.pre == ratio) ? 8'h00 : st.pre + 8'h01;
        end

        // counter; one clock domain, so a read or write is never torn
        if (wr_cnt) begin
            next_st.count = pwdata[15:0];
        end else if (tick) begin
            if (match) begin
                next_st.count = `SBT_COUNT_RST;
            end else begin
                next_st.count = st.count + 16'h0001;
            end
        end

        // software writes
        if (wr) begin
            unique case (idx)
                `SBT_IDX_PERIOD: next_st.period = pwdata[15:0];
                `SBT_IDX_CTRL: begin
                    next_st.timer_on   = pwdata[`SBT_B_TON];
                    next_st.sidl  = pwdata[`SBT_B_SIDL];
                    next_st.gated_accumulate_enable = pwdata[`SBT_B_GATED_ACCUMULATE_ENABLE];
                    next_st.ckps  = pwdata[`SBT_B_CKPS_HI:`SBT_B_CKPS_LO];
                    next_st.ext_clock_sync = pwdata[`SBT_B_EXT_CLOCK_SYNC];
                    next_st.clock_source_select   = pwdata[`SBT_B_TCS];
                end
                `SBT_IDX_FLAG:   next_st.status = st.status & ~pwdata[1:0];
                `SBT_IDX_ENABLE: next_st.mask = pwdata[1:0];
                `SBT_IDX_OSC:    next_st.lposc = pwdata[`SBT_B_LPOSC];
                default: ;
            endcase
        end

        // event flags: a set in the clearing cycle wins
        if ((tick & match) | gate_fall) begin
            next_st.status[`SBT_B_PERIOD] = 1'b1;
        end
        if (tick & match & st.lposc) begin
            next_st.status[`SBT_B_WAKE] = 1'b1;
            next_st.wake = 1'b1;
        end
        next_st.irq = |(next_st.status & next_st.mask);

        // apb answer: one wait-free access phase after setup
        next_st.pready  = psel & ~penable;
        next_st.pslverr = 1'b0;
        if (psel & ~penable) begin
            next_st.prdata = 32'h0000_0000;
            unique case (idx)
                `SBT_IDX_COUNT:  next_st.prdata[15:0] = st.count;
                `SBT_IDX_PERIOD: next_st.prdata[15:0] = st.period;
                `SBT_IDX_CTRL: next_st.prdata[15:0] = {st.timer_on, 1'b0, st.sidl,
                    6'h00, st.gated_accumulate_enable, st.ckps, 1'b0, st.ext_clock_sync, st.clock_source_select, 1'b0};
                `SBT_IDX_FLAG:   next_st.prdata[1:0] = st.status;
                `SBT_IDX_ENABLE: next_st.prdata[1:0] = st.mask;
                `SBT_IDX_OSC:    next_st.prdata[`SBT_B_LPOSC] = st.lposc;
                default:         next_st.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st        <= '0;
            st.period <= `SBT_PERIOD_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
    assign irq     = st.irq;
    assign wake    = st.wake;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_match_wrap: assert property (
        tick & match |=> st.count == 16'h0000)
        else $error("count did not return to zero on period match");

    a_flag_set: assert property (
        tick & match |=> st.status[0]
            && (irq == (st.mask[0] | (st.status[1] & st.mask[1]))))
        else $error("period flag not set on match");

    a_flag_sticky: assert property (
        st.status[0] & !(wr & idx == `SBT_IDX_FLAG & pwdata[0]) |=> st.status[0])
        else $error("period flag cleared without software");

    a_gate_fall: assert property (
        gate_fall |=> st.status[0])
        else $error("gate falling edge did not set flag");

    a_irq_masked: assert property (
        ##1 !st.mask[0] & !st.mask[1] |-> !irq)
        else $error("request with all enables clear");

    a_sleep_hold: assert property (
        cpu_sleep & (st.ext_clock_sync | !st.clock_source_select) & !wr_cnt |=> $stable(st.count))
        else $error("count moved in sleep while not asynchronous");

    a_idle_hold: assert property (
        cpu_idle & st.sidl & !wr_cnt |=> $stable(st.count))
        else $error("count moved in idle with stop-in-idle set");

    a_gate_low: assert property (
        !st.clock_source_select & st.gated_accumulate_enable & !external_clock_gate_pin & !wr_cnt |=> $stable(st.count))
        else $error("gated count moved while gate low");

    a_pre_clear: assert property (
        wr_ctl |=> st.pre == 8'h00 && st.count == $past(st.count))
        else $error("control write mishandled prescaler or count");

    a_wake_pulse: assert property (
        st.lposc & tick & match |=> wake ##1 !wake)
        else $error("carry-out wake pulse missing");

    a_lp_no_int: assert property (
        st.lposc & !st.clock_source_select & !wr_cnt |=> $stable(st.count))
        else $error("internal timer ran with low-power oscillator on");

    a_apb_ready: assert property (
        psel & !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    // the next two checks each name the one event that may move the count
    a_sync_only: assert property (
        st.clock_source_select & st.ext_clock_sync & !st.lposc & !(st.sy2 & !st.sy3) & !wr_cnt |=> $stable(st.count))
        else $error("synchronised count moved without a synchronised edge");

    a_rtc_edge: assert property (
        st.clock_source_select & st.lposc & !(lowpower_osc_in & !st.lp_q) & !wr_cnt |=> $stable(st.count))
        else $error("rtc count moved without an oscillator rising edge");

    a_count_step: assert property (
        tick & !match |=> st.count == $past(st.count) + 16'h0001)
        else $error("count did not step by one below the period");

    a_pre_cnt_clear: assert property (
        wr_cnt |=> st.pre == 8'h00)
        else $error("count write left the prescaler running");

    a_flag_clear: assert property (
        wr & (idx == `SBT_IDX_FLAG) & pwdata[0] & !(tick & match) & !gate_fall
        |=> !st.status[0])
        else $error("write of one did not clear the period flag");

    a_wake_flag: assert property (
        wake |-> st.status[1])
        else $error("wake pulse without its sticky flag");

    a_apb_error: assert property (
        pslverr |-> pready)
        else $error("error response outside the access phase");

    // rtc edges bypass the synchroniser; with the sync bit clear sleep must not starve them
    a_rtc_sleep_run: assert property (
        cpu_sleep & st.timer_on & st.clock_source_select & !st.ext_clock_sync & st.lposc & !(cpu_idle & st.sidl)
        & lowpower_osc_in & !st.lp_q & st.pre == ratio & !wr_cnt & !wr_ctl & !match
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("rtc stopped counting in sleep");

    a_gate_count: assert property (
        st.timer_on & !st.clock_source_select & st.gated_accumulate_enable & !st.lposc & external_clock_gate_pin & !cpu_sleep
        & !(cpu_idle & st.sidl) & st.pre == ratio & !wr_cnt & !wr_ctl & !match
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("gated count stalled while gate high");

    a_idle_run: assert property (
        cpu_idle & !st.sidl & st.timer_on & !st.clock_source_select & (!st.gated_accumulate_enable | external_clock_gate_pin)
        & !st.lposc & !cpu_sleep & st.pre == ratio & !wr_cnt & !wr_ctl & !match
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("count stalled in idle with stop-in-idle clear");

    c_match:  cover property (tick & match);
    c_gate:   cover property (gate_fall);
    c_wake:   cover property (wake & cpu_sleep);
    c_irq:    cover property (!irq ##1 irq);
    c_sync:   cover property (st.ext_clock_sync & tick);

endmodule : sbtrtc

// ==== tb/sbtrtc_far.sv ====
/*
 Far-side model: external clock/gate pin and oscillator output pulsed every 6 pclk cycles.
 Assumes the bench calls its tasks right after a rising pclk edge.
*/
`timescale 1ns/1ps
module sbtrtc_far (
    // clock
    input  wire logic pclk,
    // pins
    output logic      ext_pin,
    output logic      osc
);
    // both lines stand low outside frames
    initial begin
        ext_pin = 1'b0;
        osc     = 1'b0;
    end

    task automatic pulses(input int n, input bit on_osc);
        repeat (n) begin
            if (on_osc) osc <= 1'b1;
            else ext_pin <= 1'b1;
            repeat (3) @(posedge pclk);
            osc     <= 1'b0;
            ext_pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulses

    task automatic gate(input int n);
        ext_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        ext_pin <= 1'b0;
    endtask : gate
endmodule : sbtrtc_far

// ==== tb/sbtrtc_bench.sv ====
/*
 Self-checking bench of the timer: APB master, far-side model, read queue.
 Assumes sbtrtc and sbtrtc_far are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module sbtrtc_bench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        cpu_sleep = 1'b0, cpu_idle = 1'b0, pready, pslverr, irq, wake, ext_pin, osc;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h36113A61;
    logic [32:0] exp_q[$];
    int          n_fail = 0, compares = 0, n_wake = 0;
    int          rt[4] = '{1, 8, 64, 256};
    int          ex[3] = '{4, 0, 4};

    always #12.5 pclk = ~pclk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    sbtrtc sbtrtc_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_clock_gate_pin(ext_pin),
        .lowpower_osc_in(osc), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
        .irq(irq), .wake(wake));
    sbtrtc_far sbtrtc_far_inst (.pclk(pclk), .ext_pin(ext_pin), .osc(osc));

    // read at the rising edge, before the design updates its outputs
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) `CHK({pslverr, prdata}, exp_q.pop_front())
        if (wake) n_wake++;
    end

    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input bit e = 1'b0);
        exp_q.push_back({e, d});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        stop_test;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h408, 32'hFFFF);
        rd(12'h410, 32'h0);
        rd(12'h400, 32'h0);
        rd(12'h404, 32'h0, 1'b1);
        lfsr = lfsr_next(lfsr);
        wr(12'h408, {16'h0, lfsr[15:0]});
        rd(12'h408, {16'h0, lfsr[15:0]});
        wr(12'h408, 32'hFFFF);
        done("registers");
        // leftover r-1 events must be dropped by the next control write
        cpu_idle <= 1'b1;
        wr(12'h400, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(12'h410, 32'hA000 | (k << 4));
            cpu_idle <= 1'b0;
            repeat (4 * rt[k] - 1) @(posedge pclk);
            cpu_idle <= 1'b1;
            rd(12'h400, 3 * (k + 1));
        end
        done("prescale");
        wr(12'h408, 32'h2);
        wr(12'h400, 32'h0);
        wr(12'h410, 32'hA000);
        cpu_idle <= 1'b0;
        repeat (7) @(posedge pclk);
        cpu_idle <= 1'b1;
        rd(12'h400, 32'h1);
        rd(12'h440, 32'h1);
        @(posedge pclk) `CHK(irq, 1'b0)
        wr(12'h444, 32'h1);
        @(posedge pclk) `CHK(irq, 1'b1)
        wr(12'h440, 32'h1);
        @(posedge pclk) `CHK(irq, 1'b0)
        done("match");
        // idle stays high: with stop-in-idle clear the gated count must run
        wr(12'h408, 32'hFFFF);
        wr(12'h400, 32'h0);
        wr(12'h410, 32'h8040);
        sbtrtc_far_inst.gate(5);
        repeat (3) @(posedge pclk);
        rd(12'h400, 32'h5);
        rd(12'h440, 32'h1);
        wr(12'h440, 32'h1);
        cpu_idle <= 1'b0;
        done("gate");
        // s=1 asleep with sync on must hold; s=2 checks the sync path awake
        for (int s = 0; s < 3; s++) begin
            cpu_sleep <= (s < 2);
            wr(12'h410, (s == 0) ? 32'h8002 : 32'h8006);
            wr(12'h400, 32'h0);
            sbtrtc_far_inst.pulses(4, 1'b0);
            rd(12'h400, ex[s]);
        end
        done("sleep");
        cpu_sleep <= 1'b1;
        wr(12'h408, 32'h3);
        wr(12'h448, 32'h2);
        wr(12'h410, 32'h8002);
        wr(12'h400, 32'h0);
        sbtrtc_far_inst.pulses(5, 1'b1);
        rd(12'h400, 32'h1);
        rd(12'h440, 32'h3);
        wr(12'h444, 32'h2);
        wr(12'h440, 32'h1);
        @(posedge pclk) `CHK(irq, 1'b1)
        `CHK(n_wake, 1)
        wr(12'h410, 32'h8000);
        repeat (10) @(posedge pclk);
        rd(12'h400, 32'h1);
        done("rtc");
        stop_test;
    end
endmodule : sbtrtc_bench
